// ### shared/alu_pkg.sv
package alu_pkg;
    // bus and datapath widths
    localparam int unsigned BUS_W = 32;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_DEC_W = 12;
    localparam int unsigned WIN_LSB = 6;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned OP_W = 5;
    localparam int unsigned CTRL_W = 26;
    localparam int unsigned FLAG_W = 5;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_RESULT = 12'h008;
    localparam logic [11:0] OFS_PROD_LO = 12'h00C;
    localparam logic [11:0] OFS_PROD_HI = 12'h010;
    localparam logic [11:0] OFS_WREG = 12'h040;
    localparam logic [11:0] OFS_DMEM = 12'h080;
    // command word field positions
    localparam int unsigned CF_OP = 0;
    localparam int unsigned CF_BYTE = 5;
    localparam int unsigned CF_A_IDX = 6;
    localparam int unsigned CF_A_MEM = 10;
    localparam int unsigned CF_B_IDX = 11;
    localparam int unsigned CF_B_MEM = 15;
    localparam int unsigned CF_D_IDX = 16;
    localparam int unsigned CF_D_MEM = 20;
    localparam int unsigned CF_LIT = 21;
    localparam int unsigned LIT_W = 5;
    // arith_status_word bit positions and reset values
    localparam int unsigned SB_C = 0;
    localparam int unsigned SB_Z = 1;
    localparam int unsigned SB_N = 2;
    localparam int unsigned SB_RANGE = 3;
    localparam int unsigned SB_NIB = 4;
    localparam int unsigned SB_BUSY = 8;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [25:0] CTRL_RST = 26'h000_0000;
    // operation codes
    localparam logic [4:0] OP_ADD = 5'h00;
    localparam logic [4:0] OP_ADDC = 5'h01;
    localparam logic [4:0] OP_SUB = 5'h02;
    localparam logic [4:0] OP_SUBB = 5'h03;
    localparam logic [4:0] OP_AND = 5'h04;
    localparam logic [4:0] OP_IOR = 5'h05;
    localparam logic [4:0] OP_XOR = 5'h06;
    localparam logic [4:0] OP_SHL = 5'h07;
    localparam logic [4:0] OP_LSR = 5'h08;
    localparam logic [4:0] OP_ASR = 5'h09;
    localparam logic [4:0] OP_RLC = 5'h0A;
    localparam logic [4:0] OP_RRC = 5'h0B;
    localparam logic [4:0] OP_MUL_SS = 5'h10;
    localparam logic [4:0] OP_MUL_UU = 5'h11;
    localparam logic [4:0] OP_MUL_US = 5'h12;
    localparam logic [4:0] OP_MUL_SL = 5'h13;
    localparam logic [4:0] OP_MUL_UL = 5'h14;
    localparam logic [4:0] OP_MUL_BB = 5'h15;
    localparam logic [4:0] OP_DIV_S = 5'h18;
    localparam logic [4:0] OP_DIV_U = 5'h19;
    // divider timing
    localparam logic [4:0] DIV_STEPS = 5'h10;
    typedef enum logic {ST_IDLE, ST_DIV} div_state_t;
endpackage

// ### verilog/cpu_alu_with_multiplier.sv
`timescale 1ns/1ps
// Summary of operation
// - the unit works on 16-bit data and does add, subtract, shifts and bitwise logic.
// - operands are two's complement numbers for results and flags unless the op says otherwise.
// - each op updates the carry, zero, negative, overflow and nibble-carry flags it affects.
// - on subtraction carry is an inverted borrow and nibble carry an inverted nibble borrow.
// - add, subtract, logic and shift ops run at byte or word width as the command selects.
// - operands come from the working registers or data memory as the command selects.
// - the result can be written to a working register or a data memory word.
// - division by a 16-bit divisor is supported in hardware.
// - the multiplier takes 17-bit by 17-bit operands so signed and unsigned words both fit.
// - word by word multiply is offered with both signed and with both unsigned operands.
// - mixed-sign word multiply is offered, one operand unsigned and the other signed.
// - a signed or unsigned word can be multiplied by an unsigned 5-bit literal.
// - byte by byte multiply treats both bytes as unsigned.
module cpu_alu_with_multiplier #(
    parameter int unsigned NUM_WREG = 16,
    parameter int unsigned MEM_WORDS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [alu_pkg::BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [alu_pkg::BUS_W-1:0] hwdata,
    output logic [alu_pkg::BUS_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import alu_pkg::*;

    localparam int WI = $clog2(NUM_WREG);
    localparam int MI = $clog2(MEM_WORDS);

    if (NUM_WREG < 2 || NUM_WREG > 16 || (1 << WI) != NUM_WREG)
    begin : g_bad_wreg
        $error("NUM_WREG must be a power of two from 2 to 16");
    end
    if (MEM_WORDS < 2 || MEM_WORDS > 16 || (1 << MI) != MEM_WORDS)
    begin : g_bad_mem
        $error("MEM_WORDS must be a power of two from 2 to 16");
    end

    logic [15:0] wreg [NUM_WREG];
    logic [15:0] dmem [MEM_WORDS];
    logic wr_pend_r, rd_pend_r, rd_done_r, accept, wr_en;
    logic [ADDR_DEC_W-1:0] addr_r;
    logic [BUS_W-1:0] hrdata_r, rd_val;
    logic wreg_hit, dmem_hit;
    logic [CTRL_W-1:0] ctrl_r;
    logic [FLAG_W-1:0] flags_r, fl_nxt;
    logic [15:0] result_r, prod_lo_r, prod_hi_r;
    div_state_t state_r;
    logic busy, exec, valid_op, is_mul, is_div, div_start, div_zero, div_fin;
    logic [4:0] op, lit;
    logic byte_op, a_mem, b_mem, d_mem;
    logic [3:0] a_sel, b_sel, d_sel;
    logic [15:0] op_a, op_b, d_old;
    logic [15:0] xw, yw, bi, xa, ya, t;
    logic [16:0] sum;
    logic [4:0] nib;
    logic cin, is_sub, c_new, upd_c, upd_zn, upd_arith;
    logic m_as, m_bs;
    logic signed [16:0] ma, mb;
    logic signed [33:0] prod;
    logic [15:0] div_q_r, div_rem_r, div_dv_r, ua, ub, quot, remf;
    logic [4:0] div_cnt_r;
    logic div_negq_r, div_negr_r, div_sgn_r, div_dmem_r;
    logic [3:0] div_didx_r;
    logic [16:0] rem_sh, diff;
    logic dst_we, dst_mem;
    logic [3:0] dst_idx;
    logic [15:0] dst_val;

    // bus slave: reads take one wait state so a prior write has landed
    assign accept = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_r;
    assign hreadyout = !(rd_pend_r && !rd_done_r);
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= '0;
        end
        else if (hready)
        begin
            wr_pend_r <= accept && hwrite;
            rd_pend_r <= accept && !hwrite;
            addr_r <= haddr[ADDR_DEC_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_done_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            rd_done_r <= rd_pend_r && !rd_done_r;
            if (rd_pend_r && !rd_done_r)
                hrdata_r <= rd_val;
        end
    end

    assign wreg_hit = (addr_r[11:WIN_LSB] == OFS_WREG[11:WIN_LSB])
        && (32'(addr_r[5:2]) < NUM_WREG);
    assign dmem_hit = (addr_r[11:WIN_LSB] == OFS_DMEM[11:WIN_LSB])
        && (32'(addr_r[5:2]) < MEM_WORDS);
    assign busy = (state_r == ST_DIV);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (wreg_hit)
            rd_val = {16'h0000, wreg[addr_r[2 +: WI]]};
        else if (dmem_hit)
            rd_val = {16'h0000, dmem[addr_r[2 +: MI]]};
        else
            case (addr_r)
                OFS_CTRL: rd_val = {6'h00, ctrl_r};
                OFS_STATUS: rd_val = {23'h00_0000, busy, 3'h0, flags_r};
                OFS_RESULT: rd_val = {16'h0000, result_r};
                OFS_PROD_LO: rd_val = {16'h0000, prod_lo_r};
                OFS_PROD_HI: rd_val = {16'h0000, prod_hi_r};
                default: rd_val = 32'h0000_0000;
            endcase
    end

    // command decode; writing the command word starts the operation
    assign op = hwdata[CF_OP +: OP_W];
    assign byte_op = hwdata[CF_BYTE];
    assign a_sel = hwdata[CF_A_IDX +: IDX_W];
    assign a_mem = hwdata[CF_A_MEM];
    assign b_sel = hwdata[CF_B_IDX +: IDX_W];
    assign b_mem = hwdata[CF_B_MEM];
    assign d_sel = hwdata[CF_D_IDX +: IDX_W];
    assign d_mem = hwdata[CF_D_MEM];
    assign lit = hwdata[CF_LIT +: LIT_W];
    assign op_a = a_mem ? dmem[a_sel[MI-1:0]] : wreg[a_sel[WI-1:0]];
    assign op_b = b_mem ? dmem[b_sel[MI-1:0]] : wreg[b_sel[WI-1:0]];
    assign d_old = d_mem ? dmem[d_sel[MI-1:0]] : wreg[d_sel[WI-1:0]];
    assign exec = wr_en && (addr_r == OFS_CTRL) && !busy;
    assign is_mul = (op >= OP_MUL_SS) && (op <= OP_MUL_BB);
    assign is_div = (op == OP_DIV_S) || (op == OP_DIV_U);
    assign valid_op = (op <= OP_RRC) || is_mul || is_div;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= CTRL_RST;
        else if (exec)
            ctrl_r <= hwdata[CTRL_W-1:0];
    end

    // adder and shifter work in a frame whose top byte holds byte operands
    always_comb
    begin
        xw = byte_op ? {op_a[7:0], 8'h00} : op_a;
        yw = byte_op ? {op_b[7:0], 8'h00} : op_b;
        is_sub = (op == OP_SUB) || (op == OP_SUBB);
        bi = is_sub ? ~op_b : op_b;
        xa = byte_op ? {op_a[7:0], 8'hFF} : op_a;
        ya = byte_op ? {bi[7:0], 8'h00} : bi;
        cin = (op == OP_SUB) || (((op == OP_ADDC) || (op == OP_SUBB)) && flags_r[SB_C]);
        sum = {1'b0, xa} + {1'b0, ya} + {16'h0000, cin};
        nib = {1'b0, op_a[3:0]} + {1'b0, bi[3:0]} + {4'h0, cin};
        t = 16'h0000;
        c_new = flags_r[SB_C];
        upd_c = 1'b0;
        upd_zn = 1'b0;
        upd_arith = 1'b0;
        case (op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB:
            begin
                t = sum[15:0];
                c_new = sum[16];
                upd_c = 1'b1;
                upd_zn = 1'b1;
                upd_arith = 1'b1;
            end
            OP_AND, OP_IOR, OP_XOR:
            begin
                t = (op == OP_AND) ? (xw & yw) : (op == OP_IOR) ? (xw | yw) : (xw ^ yw);
                upd_zn = 1'b1;
            end
            OP_SHL, OP_RLC:
            begin
                t = {xw[14:0], 1'b0} | ((byte_op ? 16'h0100 : 16'h0001)
                    & {16{(op == OP_RLC) && flags_r[SB_C]}});
                c_new = xw[15];
                upd_c = 1'b1;
                upd_zn = 1'b1;
            end
            OP_LSR, OP_ASR, OP_RRC:
            begin
                t = {(op == OP_ASR) ? xw[15] : (op == OP_RRC) && flags_r[SB_C], xw[15:1]};
                c_new = op_a[0];
                upd_c = 1'b1;
                upd_zn = 1'b1;
            end
            default: t = 16'h0000;
        endcase
    end

    // 17x17 multiplier; the extra bit carries sign or zero extension
    always_comb
    begin
        m_as = (op == OP_MUL_SS) || (op == OP_MUL_SL);
        m_bs = (op == OP_MUL_SS) || (op == OP_MUL_US);
        ma = $signed({m_as && op_a[15], op_a});
        mb = $signed({m_bs && op_b[15], op_b});
        if ((op == OP_MUL_SL) || (op == OP_MUL_UL))
            mb = $signed({12'h000, lit});
        if (op == OP_MUL_BB)
        begin
            ma = $signed({9'h000, op_a[7:0]});
            mb = $signed({9'h000, op_b[7:0]});
        end
    end
    assign prod = ma * mb;

    // restoring divider, one quotient bit per clock
    assign ua = ((op == OP_DIV_S) && op_a[15]) ? 16'h0000 - op_a : op_a;
    assign ub = ((op == OP_DIV_S) && op_b[15]) ? 16'h0000 - op_b : op_b;
    assign div_zero = exec && is_div && (op_b == 16'h0000);
    assign div_start = exec && is_div && (op_b != 16'h0000);
    assign div_fin = busy && (div_cnt_r == DIV_STEPS);
    assign rem_sh = {div_rem_r, div_q_r[15]};
    assign diff = rem_sh - {1'b0, div_dv_r};
    assign quot = div_negq_r ? 16'h0000 - div_q_r : div_q_r;
    assign remf = div_negr_r ? 16'h0000 - div_rem_r : div_rem_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= ST_IDLE;
        else
            unique case (state_r)
                ST_IDLE: if (div_start) state_r <= ST_DIV;
                ST_DIV: if (div_fin) state_r <= ST_IDLE;
            endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q_r <= 16'h0000;
            div_rem_r <= 16'h0000;
            div_dv_r <= 16'h0000;
            div_cnt_r <= 5'h00;
            div_negq_r <= 1'b0;
            div_negr_r <= 1'b0;
            div_sgn_r <= 1'b0;
            div_dmem_r <= 1'b0;
            div_didx_r <= 4'h0;
        end
        else if (div_start)
        begin
            div_q_r <= ua;
            div_rem_r <= 16'h0000;
            div_dv_r <= ub;
            div_cnt_r <= 5'h00;
            div_negq_r <= (op == OP_DIV_S) && (op_a[15] ^ op_b[15]);
            div_negr_r <= (op == OP_DIV_S) && op_a[15];
            div_sgn_r <= (op == OP_DIV_S);
            div_dmem_r <= d_mem;
            div_didx_r <= d_sel;
        end
        else if (busy && !div_fin)
        begin
            div_rem_r <= diff[16] ? rem_sh[15:0] : diff[15:0];
            div_q_r <= {div_q_r[14:0], !diff[16]};
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end

    // destination select: divider completion or a one-cycle op
    always_comb
    begin
        dst_we = div_fin || div_zero || (exec && valid_op && !is_div);
        dst_mem = div_fin ? div_dmem_r : d_mem;
        dst_idx = div_fin ? div_didx_r : d_sel;
        if (div_fin)
            dst_val = quot;
        else if (div_zero)
            dst_val = 16'hFFFF;
        else if (is_mul)
            dst_val = prod[15:0];
        else
            dst_val = byte_op ? {d_old[15:8], t[15:8]} : t;
    end

    // flag update at the selected width
    always_comb
    begin
        fl_nxt = flags_r;
        if (div_fin)
        begin
            fl_nxt[SB_Z] = (quot == 16'h0000);
            fl_nxt[SB_N] = quot[15];
            fl_nxt[SB_RANGE] = div_sgn_r && (quot != 16'h0000) && (quot[15] != div_negq_r);
        end
        else if (div_zero)
            fl_nxt[SB_RANGE] = 1'b1;
        else
        begin
            if (upd_c)
                fl_nxt[SB_C] = c_new;
            if (upd_zn)
            begin
                fl_nxt[SB_Z] = byte_op ? (t[15:8] == 8'h00) : (t == 16'h0000);
                fl_nxt[SB_N] = t[15];
            end
            if (upd_arith)
            begin
                fl_nxt[SB_RANGE] = (xa[15] == ya[15]) && (t[15] != xa[15]);
                fl_nxt[SB_NIB] = nib[4];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flags_r <= FLAGS_RST;
        else
        begin
            if (wr_en && (addr_r == OFS_STATUS))
                flags_r <= hwdata[FLAG_W-1:0];
            if (div_fin || (exec && valid_op))
                flags_r <= fl_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_r <= 16'h0000;
            prod_lo_r <= 16'h0000;
            prod_hi_r <= 16'h0000;
        end
        else
        begin
            if (dst_we)
                result_r <= dst_val;
            if (exec && is_mul)
            begin
                prod_lo_r <= prod[15:0];
                prod_hi_r <= prod[31:16];
            end
            if (div_fin)
                prod_hi_r <= remf;
            if (div_zero)
                prod_hi_r <= op_a;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_WREG; i++)
                wreg[i] <= 16'h0000;
        end
        else
        begin
            if (wr_en && wreg_hit)
                wreg[addr_r[2 +: WI]] <= hwdata[15:0];
            if (dst_we && !dst_mem)
                wreg[dst_idx[WI-1:0]] <= dst_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                dmem[i] <= 16'h0000;
        end
        else
        begin
            if (wr_en && dmem_hit)
                dmem[addr_r[2 +: MI]] <= hwdata[15:0];
            if (dst_we && dst_mem)
                dmem[dst_idx[MI-1:0]] <= dst_val;
        end
    end

    // checks
    logic signed [31:0] chk_ss;
    logic signed [33:0] chk_us;
    logic [31:0] chk_sl;
    assign chk_ss = $signed(op_a) * $signed(op_b);
    assign chk_us = $signed({1'b0, op_a}) * $signed(op_b);
    assign chk_sl = 32'($signed(op_a)) * {27'h000_0000, lit};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_add_word: assert property (
        exec && (op == OP_ADD) && !byte_op |=> result_r == 16'($past(op_a) + $past(op_b)))
        else $error("word add result wrong");
    a_ovf_add: assert property (
        exec && (op == OP_ADD) && !byte_op |=> flags_r[SB_RANGE] ==
        (($past(op_a[15]) == $past(op_b[15])) && (result_r[15] != $past(op_a[15]))))
        else $error("add overflow flag wrong");
    a_sub_borrow: assert property (
        exec && (op == OP_SUB) && !byte_op |=> flags_r[SB_C] == ($past(op_a) >= $past(op_b)))
        else $error("subtract carry is not inverted borrow");
    a_zero_flag: assert property (
        exec && (op == OP_XOR) && !byte_op |=> flags_r[SB_Z] == ($past(op_a) == $past(op_b)))
        else $error("zero flag wrong");
    a_byte_neg: assert property (
        exec && (op == OP_IOR) && byte_op |=> (flags_r[SB_N] == ($past(op_a[7]) | $past(op_b[7])))
        && (result_r[15:8] == $past(d_old[15:8])))
        else $error("byte op negative or upper byte wrong");
    a_mul_signed: assert property (
        exec && (op == OP_MUL_SS) |=> {prod_hi_r, prod_lo_r} == $past(chk_ss))
        else $error("signed multiply wrong");
    a_mul_mixed: assert property (
        exec && (op == OP_MUL_US) |=> {prod_hi_r, prod_lo_r} == $past(chk_us[31:0]))
        else $error("mixed multiply wrong");
    a_mul_literal: assert property (
        exec && (op == OP_MUL_SL) |=> {prod_hi_r, prod_lo_r} == $past(chk_sl))
        else $error("literal multiply wrong");
    a_mul_byte: assert property (
        exec && (op == OP_MUL_BB) |=> prod_lo_r == ($past(op_a[7:0]) * $past(op_b[7:0])))
        else $error("byte multiply wrong");
    a_div_timing: assert property (
        div_start |=> busy [*8] ##1 busy [*8] ##1 busy ##1 !busy)
        else $error("divide did not take seventeen busy cycles");
    a_dest_mem: assert property (
        exec && valid_op && !is_div && d_mem |=> dmem[$past(d_sel[MI-1:0])] == result_r)
        else $error("result not written to data memory");

    c_add_carry: cover property (exec && (op == OP_ADD) ##1 flags_r[SB_C]);
    c_div_run: cover property (div_start ##18 !busy);
    c_byte_sub: cover property (exec && (op == OP_SUB) && byte_op);
    c_mul_neg: cover property (exec && (op == OP_MUL_SS) ##1 prod_hi_r[15]);
endmodule

// ### test/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // single word transfer, each phase held until hready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import alu_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q, seed;
    logic [15:0] a, b, d0, qe, re;
    logic [4:0] op, f;
    logic by, bm, dm;
    logic [20:0] e;
    int n_errors = 0;
    int tests_run = 0;
    int k;
    always #25 hclk = ~hclk;
    cpu_alu_with_multiplier i_cpu_alu_with_multiplier (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    cpu_bus_model i_cpu_bus_model (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // command word: A in wreg 1, B in wreg or mem 2, dest wreg or mem 3
    function automatic logic [31:0] cw(logic [4:0] o, logic y, logic m, logic n, logic [4:0] l);
        return {6'h00, l, n, 4'h3, m, 4'h2, 1'b0, 4'h1, y, o};
    endfunction
    function automatic logic [20:0] alu_exp(logic [4:0] o, logic y8, logic [15:0] x,
        logic [15:0] z, logic [4:0] fl);
        logic [15:0] u, v;
        logic [16:0] s;
        logic [4:0] h;
        logic ci;
        int sh;
        sh = y8 ? 8 : 0;
        if (o >= OP_SHL)
        begin
            u = y8 ? {8'h00, x[7:0]} : x;
            ci = (o == OP_RLC || o == OP_RRC) ? fl[0] : (o == OP_ASR) && u[15 - sh];
            h[0] = (o == OP_SHL || o == OP_RLC) ? u[15 - sh] : x[0];
            u = (o == OP_SHL || o == OP_RLC) ? (u << 1) | {15'h0000, ci}
                : (u >> 1) | ({15'h0000, ci} << (15 - sh));
            u = y8 ? {8'h00, u[7:0]} : u;
            return {fl[4:3], u[15 - sh], u == 16'h0000, h[0], u};
        end
        if (o >= OP_AND)
        begin
            u = o == OP_AND ? x & z : o == OP_IOR ? x | z : x ^ z;
            u = y8 ? {8'h00, u[7:0]} : u;
            return {fl[4:3], y8 ? u[7] : u[15], u == 16'h0000, fl[0], u};
        end
        v = o[1] ? ~z : z;
        ci = o[0] ? fl[0] : o[1];
        h = {1'b0, x[3:0]} + {1'b0, v[3:0]} + {4'h0, ci};
        u = x << sh;
        v = v << sh;
        s = {1'b0, u} + {1'b0, v} + ({16'h0000, ci} << sh);
        return {h[4], u[15] == v[15] && s[15] != u[15], s[15], s[15:0] == 16'h0000, s[16],
            s[15:0] >> sh};
    endfunction
    function automatic logic [31:0] mul_exp(logic [4:0] o, logic [15:0] x, logic [15:0] z,
        logic [4:0] l);
        logic [31:0] u, v;
        logic sx, sz;
        sx = (o == OP_MUL_SS || o == OP_MUL_SL) && x[15];
        sz = (o == OP_MUL_SS || o == OP_MUL_US) && z[15];
        u = {{16{sx}}, o == OP_MUL_BB ? {8'h00, x[7:0]} : x};
        v = {{16{sz}}, o == OP_MUL_BB ? {8'h00, z[7:0]} : o > OP_MUL_US ? {11'h000, l} : z};
        return u * v;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        i_cpu_bus_model.xfer(1'b1, ad, d, q);
    endtask
    task automatic rd(input logic [11:0] ad);
        i_cpu_bus_model.xfer(1'b0, ad, 32'h0000_0000, q);
    endtask
    task automatic rc(input logic [11:0] ad, input logic [31:0] ex);
        rd(ad);
        chk(q, ex);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        seed = 32'h0000_2B5E;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(OFS_STATUS, 32'h0000_0000);
        wr(12'h0FC, 32'h0000_1234);
        rc(12'h0FC, 32'h0000_0000);
        // add, subtract, logic and shift ops, corners first
        for (int i = 0; i < 48; i++)
        begin
            q = rnd();
            op = i < 4 ? 5'(i) : 5'(q[7:0] % 8'h0C);
            by = i == 1 ? 1'b1 : q[8];
            bm = q[9];
            dm = q[10];
            f = q[15:11];
            a = i == 0 ? 16'h7FFF : i == 1 ? 16'h0080 : i == 3 ? 16'h8000 : 16'(rnd());
            b = i == 1 ? 16'h0080 : i < 4 ? 16'h0001 : 16'(rnd());
            d0 = 16'(rnd());
            wr(OFS_WREG + 12'h004, {16'h0000, a});
            wr((bm ? OFS_DMEM : OFS_WREG) + 12'h008, {16'h0000, b});
            wr((dm ? OFS_DMEM : OFS_WREG) + 12'h00C, {16'h0000, d0});
            wr(OFS_STATUS, {27'h000_0000, f});
            e = alu_exp(op, by, a, b, f);
            wr(OFS_CTRL, cw(op, by, bm, dm, 5'h00));
            rc(OFS_STATUS, {27'h000_0000, e[20:16]});
            rc((dm ? OFS_DMEM : OFS_WREG) + 12'h00C, {16'h0000, by ? d0[15:8] : e[15:8],
                e[7:0]});
        end
        // every multiplier mode, sign corner then random
        for (int i = 0; i < 12; i++)
        begin
            op = OP_MUL_SS + 5'(i % 6);
            a = i < 6 ? 16'h8001 : 16'(rnd());
            b = i < 6 ? 16'hFFFF : 16'(rnd());
            f = 5'(rnd());
            wr(OFS_WREG + 12'h004, {16'h0000, a});
            wr(OFS_WREG + 12'h008, {16'h0000, b});
            wr(OFS_CTRL, cw(op, 1'b0, 1'b0, 1'b0, f));
            e[15:0] = 16'(mul_exp(op, a, b, f) >> 16);
            rc(OFS_PROD_LO, {16'h0000, 16'(mul_exp(op, a, b, f))});
            rc(OFS_PROD_HI, {16'h0000, e[15:0]});
        end
        // signed and unsigned divide, busy polled, last one by zero
        for (int i = 0; i < 7; i++)
        begin
            op = i[0] ? OP_DIV_U : OP_DIV_S;
            a = 16'(rnd());
            b = i == 6 ? 16'h0000 : 16'(rnd()) | 16'h0002;
            wr(OFS_WREG + 12'h004, {16'h0000, a});
            wr(OFS_WREG + 12'h008, {16'h0000, b});
            wr(OFS_CTRL, cw(op, 1'b0, 1'b0, 1'b0, 5'h00));
            rd(OFS_STATUS);
            chk({31'h0000_0000, q[SB_BUSY]}, {31'h0000_0000, b != 16'h0000});
            k = 0;
            while (q[SB_BUSY] !== 1'b0 && k < 20)
            begin
                rd(OFS_STATUS);
                k++;
            end
            qe = b == 16'h0000 ? 16'hFFFF : i[0] ? a / b : 16'($signed(a) / $signed(b));
            re = b == 16'h0000 ? a : i[0] ? a % b : 16'($signed(a) % $signed(b));
            rc(OFS_WREG + 12'h00C, {16'h0000, qe});
            rc(OFS_PROD_HI, {16'h0000, re});
        end
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        end_of_test();
    end
endmodule
